// ---- verilog/spcg_params.svh ----
`ifndef SPCG_PARAMS_SVH
`define SPCG_PARAMS_SVH
`define SPCG_SYSCTL_BASE 32'h400fe000
`define SPCG_RUN_CFG_OFF 12'h060
`define SPCG_RUN_GATE_OFF 12'h108
`define SPCG_SLEEP_GATE_OFF 12'h118
`define SPCG_DEEP_GATE_OFF 12'h128
`define SPCG_INT_STAT_OFF 12'h200
`define SPCG_INT_MASK_OFF 12'h204
`define SPCG_GATE_RESET 8'h00
`define SPCG_ACG_BIT 27
`define SPCG_RUN_CFG_RESET 32'h00000000
`define SPCG_NUM_PORTS 8
`define SPCG_RESP_OKAY 2'b00
`define SPCG_RESP_SLVERR 2'b10
`endif

// ---- verilog/spcg_pkg.sv ----
package spcg_pkg;
  typedef enum logic [1:0] {
    SPCG_MODE_RUN,
    SPCG_MODE_SLEEP,
    SPCG_MODE_DEEP
  } spcg_mode_e;
  typedef struct packed {
    logic valid;
    logic [2:0] port;
    logic write;
  } spcg_port_req_s;
  typedef logic [7:0] spcg_gate_t;
endpackage : spcg_pkg

// ---- verilog/spcg_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spcg_params.svh"

// What this block does
// - in sleep, a port whose sleep bit is set gets its clock and works.
// - in sleep, a port whose sleep bit is clear is unclocked and held disabled.
// - any access to an unclocked port is answered with a bus fault.
// - the register resets to zero, so every port starts unclocked.
// - bit 0 gates port a up through bit 7 for port h, all read/write.
// - bits above 7 are reserved, read-only, read as zero.
// - separate gating registers for run, sleep and deep-sleep operation.
// - sleep gating applies only while auto clock gate select is set.
// - the sleep register decodes at offset 0x118 from the system control base.
module spcg_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire spcg_pkg::spcg_mode_e i_mode,
  input wire spcg_pkg::spcg_port_req_s i_port_req,
  input wire logic [31:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [31:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output spcg_pkg::spcg_gate_t o_port_clk_en,
  output spcg_pkg::spcg_gate_t o_port_disable,
  output logic o_port_fault,
  output logic o_irq
);
  import spcg_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  spcg_gate_t run_gate_reg;
  spcg_gate_t sleep_gate_reg;
  spcg_gate_t deep_gate_reg;
  logic [31:0] run_cfg_reg;
  logic [1:0] int_stat_reg;
  logic [1:0] int_mask_reg;
  spcg_gate_t active_gate;
  logic [31:0] aw_addr_reg;
  logic aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_have_reg;
  logic do_write;
  logic do_read;
  logic access_hit;
  logic access_fault;
  logic fault_event;
  logic stat_read;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;

  // ----------------------------------------------------------------
  // gate selection
  // ----------------------------------------------------------------
  always_comb begin
    active_gate = run_gate_reg;
    if (i_mode == SPCG_MODE_SLEEP && run_cfg_reg[`SPCG_ACG_BIT]) begin
      active_gate = sleep_gate_reg;
    end else if (i_mode == SPCG_MODE_DEEP && run_cfg_reg[`SPCG_ACG_BIT]) begin
      active_gate = deep_gate_reg;
    end
    // without auto gating the run bits decide in every mode
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_port_clk_en <= `SPCG_GATE_RESET;
      o_port_disable <= ~`SPCG_GATE_RESET;
    end else begin
      o_port_clk_en <= active_gate;
      o_port_disable <= ~active_gate;
    end
  end

  // ----------------------------------------------------------------
  // port access fault
  // ----------------------------------------------------------------
  assign access_hit = i_port_req.valid;
  // judged against the enables the ports see now, not the pending selection
  assign access_fault = access_hit && !o_port_clk_en[i_port_req.port];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_port_fault <= 1'b0;
    end else begin
      o_port_fault <= access_fault;
    end
  end

  assign fault_event = access_fault;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign do_write = aw_have_reg && w_have_reg && !o_bvalid;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 32'h00000000;
      o_awready <= 1'b0;
    end else begin
      o_awready <= !aw_have_reg && !(i_awvalid && o_awready);
      if (i_awvalid && o_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end else if (do_write) begin
        aw_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      o_wready <= 1'b0;
    end else begin
      o_wready <= !w_have_reg && !(i_wvalid && o_wready);
      if (i_wvalid && o_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end else if (do_write) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_ok = 1'b1;
    if (aw_addr_reg[11:0] == `SPCG_RUN_CFG_OFF) begin
      wr_ok = 1'b1;
    end else if (aw_addr_reg[11:0] == `SPCG_RUN_GATE_OFF) begin
      wr_ok = 1'b1;
    end else if (aw_addr_reg[11:0] == `SPCG_SLEEP_GATE_OFF) begin
      wr_ok = 1'b1;
    end else if (aw_addr_reg[11:0] == `SPCG_DEEP_GATE_OFF) begin
      wr_ok = 1'b1;
    end else if (aw_addr_reg[11:0] == `SPCG_INT_STAT_OFF) begin
      wr_ok = 1'b1;
    end else if (aw_addr_reg[11:0] == `SPCG_INT_MASK_OFF) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp <= `SPCG_RESP_OKAY;
    end else begin
      if (do_write) begin
        o_bvalid <= 1'b1;
        o_bresp <= wr_ok ? `SPCG_RESP_OKAY : `SPCG_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // gating and config registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      run_gate_reg <= `SPCG_GATE_RESET;
      sleep_gate_reg <= `SPCG_GATE_RESET;
      deep_gate_reg <= `SPCG_GATE_RESET;
      run_cfg_reg <= `SPCG_RUN_CFG_RESET;
      int_mask_reg <= 2'b00;
    end else if (do_write && w_strb_reg[0]) begin
      // only byte lane 0 holds writable gate bits; upper lanes are reserved
      if (aw_addr_reg[11:0] == `SPCG_RUN_GATE_OFF) begin
        run_gate_reg <= w_data_reg[7:0];
      end else if (aw_addr_reg[11:0] == `SPCG_SLEEP_GATE_OFF) begin
        sleep_gate_reg <= w_data_reg[7:0];
      end else if (aw_addr_reg[11:0] == `SPCG_DEEP_GATE_OFF) begin
        deep_gate_reg <= w_data_reg[7:0];
      end else if (aw_addr_reg[11:0] == `SPCG_INT_MASK_OFF) begin
        int_mask_reg <= w_data_reg[1:0];
      end else if (aw_addr_reg[11:0] == `SPCG_RUN_CFG_OFF) begin
        run_cfg_reg[7:0] <= w_data_reg[7:0];
      end
    end else if (do_write && w_strb_reg[3] && aw_addr_reg[11:0] == `SPCG_RUN_CFG_OFF) begin
      run_cfg_reg[31:24] <= w_data_reg[31:24];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign do_read = i_arvalid && o_arready;

  always_comb begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    if (i_araddr[11:0] == `SPCG_RUN_CFG_OFF) begin
      rd_word = run_cfg_reg;
    end else if (i_araddr[11:0] == `SPCG_RUN_GATE_OFF) begin
      rd_word = {24'h000000, run_gate_reg};
    end else if (i_araddr[11:0] == `SPCG_SLEEP_GATE_OFF) begin
      rd_word = {24'h000000, sleep_gate_reg};
    end else if (i_araddr[11:0] == `SPCG_DEEP_GATE_OFF) begin
      rd_word = {24'h000000, deep_gate_reg};
    end else if (i_araddr[11:0] == `SPCG_INT_STAT_OFF) begin
      rd_word = {30'h00000000, int_stat_reg};
    end else if (i_araddr[11:0] == `SPCG_INT_MASK_OFF) begin
      rd_word = {30'h00000000, int_mask_reg};
    end else begin
      rd_ok = 1'b0;
    end
  end

  assign stat_read = do_read && i_araddr[11:0] == `SPCG_INT_STAT_OFF;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= `SPCG_RESP_OKAY;
    end else begin
      o_arready <= !o_rvalid && !do_read;
      if (do_read) begin
        o_rvalid <= 1'b1;
        o_rdata <= rd_word;
        o_rresp <= rd_ok ? `SPCG_RESP_OKAY : `SPCG_RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  // bit 0: access to unclocked port; bit 1: set every cycle while in sleep with auto gating and no sleep bit set
  logic sleep_empty;
  assign sleep_empty = i_mode == SPCG_MODE_SLEEP && run_cfg_reg[`SPCG_ACG_BIT]
    && sleep_gate_reg == `SPCG_GATE_RESET;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      int_stat_reg <= 2'b00;
    end else begin
      // set wins over the read-clear in the same cycle
      int_stat_reg <= (stat_read ? 2'b00 : int_stat_reg) | {sleep_empty, fault_event};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(int_stat_reg & int_mask_reg);
    end
  end

endmodule : spcg_top
`default_nettype wire

// ---- verification/spcg_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port gating and bus handshake checker
// ----------------------------------------
module spcg_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire spcg_pkg::spcg_port_req_s i_port_req,
  input wire logic i_bready,
  input wire logic i_rready,
  input wire logic o_bvalid,
  input wire logic o_rvalid,
  input wire spcg_pkg::spcg_gate_t o_port_clk_en,
  input wire spcg_pkg::spcg_gate_t o_port_disable,
  input wire logic o_port_fault
);
  import spcg_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_disable_inverse: assert property (o_port_disable == ~o_port_clk_en)
    else $error("port disable is not the inverse of clock enable");
  chk_fault_unclocked: assert property (
    i_port_req.valid && !o_port_clk_en[i_port_req.port] |=> o_port_fault)
    else $error("access to unclocked port gave no fault");
  chk_fault_clocked: assert property (
    i_port_req.valid && o_port_clk_en[i_port_req.port] |=> !o_port_fault)
    else $error("access to clocked port gave a fault");
  chk_fault_idle: assert property (o_port_fault |-> $past(i_port_req.valid))
    else $error("fault without an access");
  chk_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response dropped early");
  chk_rvalid_hold: assert property (o_rvalid && !i_rready |=> $stable(o_rvalid))
    else $error("read response dropped early");
  chk_bvalid_once: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("write response repeated");
  chk_rvalid_once: assert property (o_rvalid && i_rready |=> !o_rvalid)
    else $error("read response repeated");
endmodule : spcg_checker
bind spcg_top spcg_checker u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_port_req(i_port_req),
  .i_bready(i_bready), .i_rready(i_rready), .o_bvalid(o_bvalid), .o_rvalid(o_rvalid),
  .o_port_clk_en(o_port_clk_en), .o_port_disable(o_port_disable), .o_port_fault(o_port_fault));
`default_nettype wire

// ---- verification/sleep_port_clock_gating_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spcg_params.svh"
`define CMP(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module sleep_port_clock_gating_test;
  import spcg_pkg::*;
  logic i_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_port_fault, o_irq;
  logic [31:0] i_awaddr, i_wdata, i_araddr, o_rdata, rd;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp, rsp;
  spcg_mode_e i_mode;
  spcg_port_req_s i_port_req;
  spcg_gate_t o_port_clk_en, o_port_disable;
  int err_total = 0, checks_done = 0, cyc = 0;
  spcg_top DUT (.i_clk, .i_rst, .i_mode, .i_port_req, .i_awaddr, .i_awvalid, .o_awready,
    .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_port_clk_en,
    .o_port_disable, .o_port_fault, .o_irq);
  initial begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  // handshakes are judged at the settled negedge, released after the next posedge
  task automatic wr(input logic [11:0] off, input logic [31:0] d, input logic [3:0] s);
    logic a, w, b;
    b = 1'h0;
    @(posedge i_clk);
    i_awaddr <= `SPCG_SYSCTL_BASE | off;
    i_wdata <= d;
    i_wstrb <= s;
    {i_awvalid, i_wvalid, i_bready} <= 3'h7;
    while (!b) begin
      @(negedge i_clk);
      a = i_awvalid & o_awready;
      w = i_wvalid & o_wready;
      b = o_bvalid;
      rsp = o_bresp;
      @(posedge i_clk);
      if (a) i_awvalid <= 1'h0;
      if (w) i_wvalid <= 1'h0;
      if (b) i_bready <= 1'h0;
    end
  endtask : wr
  task automatic rdr(input logic [11:0] off);
    logic a, b;
    b = 1'h0;
    @(posedge i_clk);
    i_araddr <= `SPCG_SYSCTL_BASE | off;
    {i_arvalid, i_rready} <= 2'h3;
    while (!b) begin
      @(negedge i_clk);
      a = i_arvalid & o_arready;
      b = o_rvalid;
      rd = o_rdata;
      rsp = o_rresp;
      @(posedge i_clk);
      if (a) i_arvalid <= 1'h0;
      if (b) i_rready <= 1'h0;
    end
  endtask : rdr
  task automatic preq(input logic [2:0] p, input logic e);
    @(posedge i_clk);
    i_port_req <= '{1'h1, p, 1'h0};
    @(posedge i_clk);
    i_port_req <= '0;
    @(negedge i_clk);
    `CMP("port fault", e, o_port_fault)
  endtask : preq
  task automatic settle;
    repeat (3) @(negedge i_clk);
  endtask : settle
  task automatic report_and_stop;
    if (err_total == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      report_and_stop;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h20;
    {i_awaddr, i_wdata, i_araddr, i_wstrb} = '0;
    i_mode = SPCG_MODE_RUN;
    i_port_req = '0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'h0;
    @(posedge i_clk);
    rdr(`SPCG_SLEEP_GATE_OFF);
    `CMP("sleep reset", 32'h0, rd)
    `CMP("clk en reset", 8'h00, o_port_clk_en)
    `CMP("disable reset", 8'hff, o_port_disable)
    wr(`SPCG_SLEEP_GATE_OFF, 32'hffffffff, 4'h1);
    rdr(`SPCG_SLEEP_GATE_OFF);
    `CMP("reserved bits", 32'h000000ff, rd)
    `CMP("read resp", `SPCG_RESP_OKAY, rsp)
    wr(`SPCG_RUN_CFG_OFF, 32'h08000000, 4'h8);
    i_mode <= SPCG_MODE_SLEEP;
    for (int i = 0; i < 8; i++) begin
      wr(`SPCG_SLEEP_GATE_OFF, 32'h1 << i, 4'h1);
      settle;
      `CMP("sleep clk en", 8'h1 << i, o_port_clk_en)
      `CMP("sleep disable", ~(8'h1 << i), o_port_disable)
      rdr(`SPCG_SLEEP_GATE_OFF);
      `CMP("gate bit", 32'h1 << i, rd)
      preq(i[2:0], 1'h0);
      preq(i[2:0] + 3'h1, 1'h1);
    end
    // faults above left the status bit set while still masked
    `CMP("irq masked", 1'h0, o_irq)
    wr(`SPCG_INT_MASK_OFF, 32'h1, 4'h1);
    settle;
    `CMP("irq raised", 1'h1, o_irq)
    rdr(`SPCG_INT_STAT_OFF);
    `CMP("fault status", 32'h1, rd & 32'h1)
    rdr(`SPCG_INT_STAT_OFF);
    `CMP("status cleared", 32'h0, rd & 32'h1)
    wr(`SPCG_SLEEP_GATE_OFF, 32'h0, 4'h1);
    settle;
    rdr(`SPCG_INT_STAT_OFF);
    `CMP("empty sleep status", 32'h2, rd & 32'h2)
    settle;
    `CMP("irq cleared", 1'h0, o_irq)
    wr(`SPCG_RUN_GATE_OFF, 32'h5a, 4'h1);
    wr(`SPCG_DEEP_GATE_OFF, 32'h3c, 4'h1);
    i_mode <= SPCG_MODE_RUN;
    settle;
    `CMP("run clk en", 8'h5a, o_port_clk_en)
    i_mode <= SPCG_MODE_DEEP;
    settle;
    `CMP("deep clk en", 8'h3c, o_port_clk_en)
    wr(`SPCG_RUN_CFG_OFF, 32'h0, 4'h8);
    i_mode <= SPCG_MODE_SLEEP;
    settle;
    `CMP("no auto gate", 8'h5a, o_port_clk_en)
    rdr(12'h3f0);
    `CMP("unmapped read", `SPCG_RESP_SLVERR, rsp)
    `CMP("unmapped data", 32'h0, rd)
    wr(12'h3f0, 32'h1, 4'hf);
    `CMP("unmapped write", `SPCG_RESP_SLVERR, rsp)
    report_and_stop;
  end
endmodule : sleep_port_clock_gating_test
`default_nettype wire
